// ==== dv/tb_top.sv ====
// self-checking bench for the voice codec core interface
// assumes the comb model in this folder and the monitor bound below
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        ref_clk = 1'h0, arst_n = 1'h0, sw_reset = 1'h0;
  logic        core_rd_en = 1'h0, core_wr_en = 1'h0;
  logic [1:0]  core_addr = 2'h0;
  logic [15:0] core_wdata = 16'h0000, core_rdata, dac_word, adc_word, rv;
  logic        adc_word_valid, dac_sample_req, dac_word_valid, mute_n_bit, codec_irq;
  logic        input_select_bit, codec_enable_bit;
  logic [3:0]  output_level_code;
  logic [7:0]  output_level_db, ratio_value, dac_gain_num;
  logic [1:0]  mic_gain_field;
  int          err_total = 0, samples_checked = 0, cycles = 0;
  logic [7:0]  db_t [16] = '{8'hEC, 8'hF1, 8'hF6, 8'hFB, 8'h00, 8'h06, 8'h0C, 8'h12,
                             8'h00, 8'h06, 8'h0C, 8'h12, 8'h18, 8'h1E, 8'h1E, 8'h23};
  logic [7:0]  rt_t [4] = '{8'h7D, 8'h80, 8'h69, 8'h51};

  vci_core uut (.ref_clk, .arst_n, .sw_reset, .core_addr, .core_rd_en, .core_wr_en,
    .core_wdata, .core_rdata, .adc_word_valid, .adc_word, .dac_sample_req, .dac_word,
    .dac_word_valid, .output_level_code, .output_level_db, .ratio_value, .dac_gain_num,
    .mute_n_bit, .mic_gain_field, .input_select_bit, .codec_enable_bit, .codec_irq);
  vci_comb_model comb (.ref_clk, .adc_word_valid, .adc_word, .dac_sample_req);

  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // shared bus and compare tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #3;
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk) #2;
    core_addr = a;
    core_wdata = d;
    core_wr_en = 1'h1;
    @(posedge ref_clk) #2;
    core_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge ref_clk) #2;
    core_addr = a;
    core_rd_en = 1'h1;
    @(posedge ref_clk) #2;
    core_rd_en = 1'h0;
    @(posedge ref_clk) #1;
    v = core_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(2'h2, rv);
    chk(rv, 16'h0000);
    rd(2'h1, rv);
    chk(rv, 16'h0004);
    wr(2'h3, 16'hFFFF);
    rd(2'h3, rv);
    chk(rv, 16'h0000);
    chk(codec_irq, 16'h0000);
  endtask
  task automatic t_ctrl();
    wr(2'h2, 16'hFFFF);
    rd(2'h2, rv);
    chk(rv, 16'hFF0F);
    chk(codec_enable_bit, 16'h0001);
    for (int i = 0; i < 16; i++) begin
      wr(2'h2, {2'h1, i[0], i[1:0], i[0], i[1:0], 4'h0, i[3:0]});
      cyc(3);
      chk(output_level_db, db_t[i]);
      chk(ratio_value, rt_t[i[1:0]]);
      chk(dac_gain_num, rt_t[i[1:0]]);
      chk({mute_n_bit, mic_gain_field}, {i[0], i[1:0]});
      chk(input_select_bit, i[0]);
    end
  endtask
  task automatic t_rx();
    wr(2'h2, 16'h4000);
    comb.send_adc(16'h0123);
    comb.send_adc(16'h7FFF);
    rd(2'h1, rv);
    chk(rv, 16'h000E);
    wr(2'h0, 16'h1111);
    rd(2'h1, rv);
    chk(rv, 16'h000A);
    wr(2'h2, 16'hC000);
    cyc(3);
    chk(codec_irq, 16'h0001);
    rd(2'h0, rv);
    chk(rv, 16'h7FFF);
    cyc(3);
    chk(codec_irq, 16'h0000);
  endtask
  task automatic t_tx();
    wr(2'h0, 16'h1234);
    comb.req_dac();
    chk({dac_word_valid, dac_word}, {1'h1, 16'h1234});
    cyc(3);
    chk(codec_irq, 16'h0001);
    rd(2'h0, rv);
    chk(rv, 16'h7FFF);
    comb.req_dac();
    chk(dac_word, 16'h1234);
    rd(2'h1, rv);
    chk(rv, 16'h0005);
  endtask
  task automatic t_pd();
    wr(2'h2, 16'h8000);
    cyc(2);
    chk(codec_enable_bit, 16'h0000);
    comb.send_adc(16'h0042);
    rd(2'h1, rv);
    chk(rv, 16'h0005);
    wr(2'h0, 16'h5555);
    rd(2'h1, rv);
    chk(rv, 16'h0000);
    @(posedge ref_clk) #2;
    sw_reset = 1'h1;
    @(posedge ref_clk) #2;
    sw_reset = 1'h0;
    rd(2'h2, rv);
    chk(rv, 16'h0000);
    rd(2'h1, rv);
    chk(rv, 16'h0004);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    #2;
    arst_n = 1'h1;
    t_reset();
    t_ctrl();
    t_rx();
    t_tx();
    t_pd();
    stop_test();
  end
endmodule

bind vci_core vci_core_monitor mon (.ref_clk, .arst_n, .sw_reset, .core_addr, .core_rd_en,
  .core_wr_en, .core_wdata, .core_rdata, .dac_sample_req, .dac_word_valid,
  .output_level_code, .ratio_value, .dac_gain_num, .mute_n_bit, .mic_gain_field,
  .input_select_bit, .codec_enable_bit, .codec_irq);

`default_nettype wire

// ==== dv/vci_comb_model.sv ====
// behavioural comb filter side: decimator result pulses, interpolator requests
// assumes the testbench calls its tasks; drives just after the rising edge
`timescale 1ns/1ns
`default_nettype none

module vci_comb_model (
  input  wire logic        ref_clk,
  output var  logic        adc_word_valid,
  output var  logic [15:0] adc_word,
  output var  logic        dac_sample_req
);
  initial begin
    adc_word_valid = 1'h0;
    adc_word = 16'h0000;
    dac_sample_req = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle result pulse; word is inverted afterwards so no stale value looks valid
  task automatic send_adc(input logic [15:0] w);
    @(posedge ref_clk) #2;
    adc_word = w;
    adc_word_valid = 1'h1;
    @(posedge ref_clk) #2;
    adc_word_valid = 1'h0;
    adc_word = ~w;
  endtask

  // one-cycle request, returns just after the edge that answers it
  task automatic req_dac();
    @(posedge ref_clk) #2;
    dac_sample_req = 1'h1;
    @(posedge ref_clk) #2;
    dac_sample_req = 1'h0;
  endtask
endmodule

`default_nettype wire

// ==== dv/vci_core_monitor.sv ====
// concurrent checks on the ports of the voice codec core interface
// assumes a bind from the testbench top and one clock domain on ref_clk
`timescale 1ns/1ns
`default_nettype none

module vci_core_monitor (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        sw_reset,
  input wire logic [1:0]  core_addr,
  input wire logic        core_rd_en,
  input wire logic        core_wr_en,
  input wire logic [15:0] core_wdata,
  input wire logic [15:0] core_rdata,
  input wire logic        dac_sample_req,
  input wire logic        dac_word_valid,
  input wire logic [3:0]  output_level_code,
  input wire logic [7:0]  ratio_value,
  input wire logic [7:0]  dac_gain_num,
  input wire logic        mute_n_bit,
  input wire logic [1:0]  mic_gain_field,
  input wire logic        input_select_bit,
  input wire logic        codec_enable_bit,
  input wire logic        codec_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////
  // bus side: decoded outputs lag a control write by two edges
  ctrl_rsvd_a: assert property (core_rd_en && core_addr == 2'h2
    |=> core_rdata[7:4] == 4'h0)
    else $error("reserved control bits read nonzero");
  unmapped_rd_a: assert property (core_rd_en && core_addr == 2'h3
    |=> core_rdata == 16'h0000)
    else $error("unmapped location read nonzero");
  rdata_hold_a: assert property (!$past(core_rd_en) |-> $stable(core_rdata))
    else $error("read data moved without a read");
  ctrl_field_a: assert property ((core_wr_en && core_addr == 2'h2 && !sw_reset) ##1
    (!(core_wr_en && core_addr == 2'h2) && !sw_reset) |=>
    {codec_enable_bit, input_select_bit, mic_gain_field, mute_n_bit, output_level_code}
    == {$past(core_wdata[14:10], 2), $past(core_wdata[3:0], 2)})
    else $error("control fields differ from written word");
  ratio_map_a: assert property ((core_wr_en && core_addr == 2'h2 && !sw_reset) ##1
    (!(core_wr_en && core_addr == 2'h2) && !sw_reset) |=> ratio_value ==
    ($past(core_wdata[9:8], 2) == 2'h0 ? 8'h7D : $past(core_wdata[9:8], 2) == 2'h1 ? 8'h80 :
     $past(core_wdata[9:8], 2) == 2'h2 ? 8'h69 : 8'h51))
    else $error("ratio does not follow ratio field");
  gain_ratio_a: assert property (dac_gain_num == ratio_value)
    else $error("interpolator gain differs from ratio");
  // irq can only rise once the interrupt enable bit is set, seen here through a control read
  irq_off_a: assert property ((core_rd_en && core_addr == 2'h2 && !core_wr_en) ##1
    (!core_rdata[15] && !core_wr_en) |-> !codec_irq ##1 !codec_irq)
    else $error("interrupt raised while disabled");
  // the registered enable seen one edge later is the one the request met
  dac_resp_a: assert property (dac_sample_req |=> dac_word_valid == codec_enable_bit)
    else $error("sample valid does not match enable state");
  valid_pulse_a: assert property (dac_word_valid && !dac_sample_req |=> !dac_word_valid)
    else $error("sample valid longer than one cycle");
endmodule

`default_nettype wire

// ==== src/vci_consts.vh ====
// constants shared by the voice codec core interface files
// assumes inclusion by bare name from the core and decode design files of the block
`ifndef VCI_CONSTS_VH
`define VCI_CONSTS_VH

// data memory locations seen by the core (index on core_addr)
`define VCI_LOC_DATA      2'h0
`define VCI_LOC_STAT      2'h1
`define VCI_LOC_CTRL      2'h2

// codec_control_reg field positions
`define VCI_LEVEL_LSB     0
`define VCI_LEVEL_MSB     3
`define VCI_RATIO_LSB     8
`define VCI_RATIO_MSB     9
`define VCI_MUTE_N_BIT    10
`define VCI_MGAIN_LSB     11
`define VCI_MGAIN_MSB     12
`define VCI_INSEL_BIT     13
`define VCI_ENABLE_BIT    14
`define VCI_IRQEN_BIT     15

// writable bits of codec_control_reg, bits 7..4 are reserved
`define VCI_CTRL_WMASK    16'hFF0F
`define VCI_CTRL_RESET    16'h0000

// codec_flag_reg bit positions
`define VCI_UNDERRUN_BIT  0
`define VCI_OVERRUN_BIT   1
`define VCI_TXEMPTY_BIT   2
`define VCI_RXFULL_BIT    3

// flag reset values
`define VCI_TXEMPTY_RESET 1'h1
`define VCI_RXFULL_RESET  1'h0
`define VCI_ERR_RESET     1'h0

// common comb ratios; gain numerator over 128
`define VCI_RATIO_00      8'h7D
`define VCI_RATIO_01      8'h80
`define VCI_RATIO_10      8'h69
`define VCI_RATIO_11      8'h51
`define VCI_DATA_RESET    16'h0000

`endif

// ==== src/vci_core.v ====
// voice codec core interface: sample, flag and control registers
// assumes a core bus with one-cycle read and write strobes, and comb
// filters that present one-cycle sample pulses on ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "vci_consts.vh"

module vci_core (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        sw_reset,
  input  wire [1:0]  core_addr,
  input  wire        core_rd_en,
  input  wire        core_wr_en,
  input  wire [15:0] core_wdata,
  output reg  [15:0] core_rdata,
  input  wire        adc_word_valid,
  input  wire [15:0] adc_word,
  input  wire        dac_sample_req,
  output reg  [15:0] dac_word,
  output reg         dac_word_valid,
  output reg  [3:0]  output_level_code,
  output reg  [7:0]  output_level_db,
  output reg  [7:0]  ratio_value,
  output reg  [7:0]  dac_gain_num,
  output reg         mute_n_bit,
  output reg  [1:0]  mic_gain_field,
  output reg         input_select_bit,
  output reg         codec_enable_bit,
  output reg         codec_irq
);

  ////////////////////////////////////////////////////////////////////////
  // storage
  reg  [15:0] codec_control_reg;
  reg  [15:0] codec_control_next;
  reg  [15:0] receive_sample_reg;
  reg  [15:0] transmit_sample_reg;
  reg         underrun_arm_reg;
  reg         overrun_arm_reg;

  wire        receive_full_flag;
  wire        transmit_empty_flag;
  wire        underrun_flag;
  wire        overrun_flag;
  wire [7:0]  dec_level_db;
  wire [7:0]  dec_ratio_value;
  wire [7:0]  dec_gain_num;

  ////////////////////////////////////////////////////////////////////////
  // core access decode; data location is shared by receive and transmit
  wire data_rd  = core_rd_en && (core_addr == `VCI_LOC_DATA);
  wire data_wr  = core_wr_en && (core_addr == `VCI_LOC_DATA);
  wire stat_rd  = core_rd_en && (core_addr == `VCI_LOC_STAT);
  wire ctrl_wr  = core_wr_en && (core_addr == `VCI_LOC_CTRL);

  // enable and interrupt enable as currently stored
  wire enabled  = codec_control_reg[`VCI_ENABLE_BIT];
  wire irq_en   = codec_control_reg[`VCI_IRQEN_BIT];

  // falling edge of the enable bit caused by a core write;
  // a software reset needs no entry pulse, it restarts every flag anyway
  wire pd_entry = ctrl_wr && enabled && !core_wdata[`VCI_ENABLE_BIT];

  // comb pulses are ignored while powered down,
  // so a stale result from a waking filter never reaches the core
  wire adc_take = adc_word_valid && enabled;
  wire dac_take = dac_sample_req && enabled;

  // status clears armed by a read of the flag location with the flag set
  wire underrun_clr = data_wr && underrun_arm_reg;
  wire overrun_clr  = data_rd && overrun_arm_reg;

  ////////////////////////////////////////////////////////////////////////
  // control register next value; reserved bits never store a one
  // a software reset beats a write in the same cycle
  always @* begin
    codec_control_next = codec_control_reg;
    if (sw_reset) begin
      codec_control_next = `VCI_CTRL_RESET;
    end else if (ctrl_wr) begin
      codec_control_next = core_wdata & `VCI_CTRL_WMASK;
    end
  end

  // control register state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      codec_control_reg <= `VCI_CTRL_RESET;
    end else begin
      codec_control_reg <= codec_control_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive sample: taken unchanged so a full-scale 7FFF passes intact
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      receive_sample_reg <= `VCI_DATA_RESET;
    end else if (adc_take) begin
      receive_sample_reg <= adc_word;
    end
  end

  // transmit sample: only the core writes it, kept for resending
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_sample_reg <= `VCI_DATA_RESET;
    end else if (data_wr) begin
      transmit_sample_reg <= core_wdata;
    end
  end

  // interpolator feed: last written word goes out on every request taken while enabled,
  // so a missed write simply repeats the previous sample
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_word       <= `VCI_DATA_RESET;
      dac_word_valid <= 1'h0;
    end else begin
      dac_word_valid <= dac_take;
      if (dac_take) begin
        dac_word <= transmit_sample_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive-full: set by a new result, cleared by a read or power-down
  vci_sticky_flag #(
    .RESET_VAL (`VCI_RXFULL_RESET)
  ) u_rx_full (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .restart  (sw_reset),
    .set_ev   (adc_take),
    .clr_ev   (data_rd || pd_entry),
    .flag_reg (receive_full_flag)
  );

  // transmit-empty: set by a transfer, power-down entry and any reset
  vci_sticky_flag #(
    .RESET_VAL (`VCI_TXEMPTY_RESET)
  ) u_tx_empty (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .restart  (sw_reset),
    .set_ev   (dac_take || pd_entry),
    .clr_ev   (data_wr),
    .flag_reg (transmit_empty_flag)
  );

  // underrun: a due sample found the transmit side still empty
  // the resend itself needs nothing here; dac_word is reloaded from transmit_sample_reg as it stands
  vci_sticky_flag #(
    .RESET_VAL (`VCI_ERR_RESET)
  ) u_underrun (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .restart  (sw_reset),
    .set_ev   (dac_take && transmit_empty_flag),
    .clr_ev   (underrun_clr),
    .flag_reg (underrun_flag)
  );

  // overrun: a new result landed on an unread one, which is overwritten
  // the older word is lost; only the flag tells software about it
  vci_sticky_flag #(
    .RESET_VAL (`VCI_ERR_RESET)
  ) u_overrun (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .restart  (sw_reset),
    .set_ev   (adc_take && receive_full_flag),
    .clr_ev   (overrun_clr),
    .flag_reg (overrun_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // clear-sequence arming; power-down leaves the error flags alone
  // an arm outlives any number of further flag reads until it is used
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      underrun_arm_reg <= 1'h0;
      overrun_arm_reg  <= 1'h0;
    end else if (sw_reset) begin
      underrun_arm_reg <= 1'h0;
      overrun_arm_reg  <= 1'h0;
    end else begin
      if (stat_rd && underrun_flag) begin
        underrun_arm_reg <= 1'h1;
      end else if (underrun_clr) begin
        underrun_arm_reg <= 1'h0;
      end
      if (stat_rd && overrun_flag) begin
        overrun_arm_reg <= 1'h1;
      end else if (overrun_clr) begin
        overrun_arm_reg <= 1'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode, registered below so every output leaves a flop
  vci_ctrl_decode u_decode (
    .level_code  (codec_control_reg[`VCI_LEVEL_MSB:`VCI_LEVEL_LSB]),
    .ratio_code  (codec_control_reg[`VCI_RATIO_MSB:`VCI_RATIO_LSB]),
    .level_db    (dec_level_db),
    .ratio_value (dec_ratio_value),
    .gain_num    (dec_gain_num)
  );

  // analog-side controls follow the control register with one cycle lag;
  // input select needs no quiet period, it simply follows the bit
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      output_level_code <= 4'h0;
      output_level_db   <= 8'h00;
      ratio_value       <= 8'h00;
      dac_gain_num      <= 8'h00;
      mute_n_bit        <= 1'h0;
      mic_gain_field    <= 2'h0;
      input_select_bit  <= 1'h0;
      codec_enable_bit  <= 1'h0;
    end else begin
      output_level_code <= codec_control_reg[`VCI_LEVEL_MSB:`VCI_LEVEL_LSB];
      output_level_db   <= dec_level_db;
      ratio_value       <= dec_ratio_value;
      dac_gain_num      <= dec_gain_num;
      mute_n_bit        <= codec_control_reg[`VCI_MUTE_N_BIT];
      mic_gain_field    <= codec_control_reg[`VCI_MGAIN_MSB:`VCI_MGAIN_LSB];
      input_select_bit  <= codec_control_reg[`VCI_INSEL_BIT];
      codec_enable_bit  <= enabled;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one shared request for both directions, gated by interrupt enable
  // a level, not a pulse: it stays up until both flags are serviced
  // or the interrupt enable bit is cleared
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      codec_irq <= 1'h0;
    end else begin
      codec_irq <= irq_en && (receive_full_flag || transmit_empty_flag);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data: three locations, reserved and unmapped bits read zero;
  // the shared data location never returns the transmit word
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_rdata <= 16'h0000;
    end else if (core_rd_en) begin
      case (core_addr)
        `VCI_LOC_DATA: begin
          core_rdata <= receive_sample_reg;
        end
        `VCI_LOC_STAT: begin
          core_rdata <= {12'h000, receive_full_flag, transmit_empty_flag,
                         overrun_flag, underrun_flag};
        end
        `VCI_LOC_CTRL: begin
          core_rdata <= codec_control_reg;
        end
        default: begin
          core_rdata <= 16'h0000;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== src/vci_ctrl_decode.v ====
// decodes control fields into level, ratio and interpolator gain
// assumes a caller that registers the results before they leave the block
`timescale 1ns/1ns
`default_nettype none
`include "vci_consts.vh"

module vci_ctrl_decode (
  input  wire [3:0] level_code,
  input  wire [1:0] ratio_code,
  output reg  [7:0] level_db,
  output reg  [7:0] ratio_value,
  output reg  [7:0] gain_num
);

  ////////////////////////////////////////////////////////////////////////
  // output level in dB, two's complement; note 1101 and 1110 alias
  always @* begin
    case (level_code)
      4'h0:    level_db = 8'hEC;  // -20
      4'h1:    level_db = 8'hF1;  // -15
      4'h2:    level_db = 8'hF6;  // -10
      4'h3:    level_db = 8'hFB;  // -5
      4'h4:    level_db = 8'h00;
      4'h5:    level_db = 8'h06;
      4'h6:    level_db = 8'h0C;
      4'h7:    level_db = 8'h12;
      4'h8:    level_db = 8'h00;
      4'h9:    level_db = 8'h06;
      4'hA:    level_db = 8'h0C;
      4'hB:    level_db = 8'h12;
      4'hC:    level_db = 8'h18;
      4'hD:    level_db = 8'h1E;
      4'hE:    level_db = 8'h1E;
      default: level_db = 8'h23;
    endcase
  end

  // one ratio drives both combs; gain over 128 equals the ratio itself
  always @* begin
    case (ratio_code)
      2'h0:    ratio_value = `VCI_RATIO_00;
      2'h1:    ratio_value = `VCI_RATIO_01;
      2'h2:    ratio_value = `VCI_RATIO_10;
      default: ratio_value = `VCI_RATIO_11;
    endcase
    gain_num = ratio_value;
  end

endmodule

`default_nettype wire

// ==== src/vci_sticky_flag.v ====
// one sticky status flag with set-over-clear priority
// assumes set, clear and restart are synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none

module vci_sticky_flag #(
  parameter [0:0] RESET_VAL = 1'h0
) (
  input  wire ref_clk,
  input  wire arst_n,
  input  wire restart,
  input  wire set_ev,
  input  wire clr_ev,
  output reg  flag_reg
);

  reg flag_next;

  ////////////////////////////////////////////////////////////////////////
  // next state: an event landing on a clear is never lost
  always @* begin
    flag_next = flag_reg;
    if (restart) begin
      flag_next = RESET_VAL;
    end else if (set_ev) begin
      flag_next = 1'h1;
    end else if (clr_ev) begin
      flag_next = 1'h0;
    end
  end

  // state
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= RESET_VAL;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule

`default_nettype wire
